// file: hdl/pti_map.svh
// offsets, field positions, reset values and timing figures of the safety input block
`ifndef PTI_MAP_SVH
`define PTI_MAP_SVH

// clock rate and time figures
`define PTI_CLK_MHZ 125
`define PTI_SLOT_US 500
`define PTI_BLINK_MS 250

// register byte offsets
`define PTI_OFS_CTRL 8'h00
`define PTI_OFS_STATUS 8'h04
`define PTI_OFS_MASK 8'h08
`define PTI_OFS_INPUT 8'h0c
`define PTI_OFS_FAULT 8'h10
`define PTI_OFS_ADDR 8'h14
`define PTI_OFS_CFGADDR 8'h18

// control bit positions
`define PTI_CTRL_ACK 0

// status and mask bit positions
`define PTI_ST_CROSS 0
`define PTI_ST_SHORT 1
`define PTI_ST_COMM 2
`define PTI_ST_DATA 3
`define PTI_ST_INT 4
`define PTI_ST_ADDR 5
`define PTI_ST_W 6

// field positions in the readback words
`define PTI_INPUT_RAW_LSB 8
`define PTI_FAULT_SHORT_LSB 8
`define PTI_ADDR_MISMATCH 16

// reset values
`define PTI_MASK_RST 6'h00
`define PTI_CFGADDR_RST 10'h000

`endif

// file: hdl/pti_pkg.sv
// types shared by the safety input block
package pti_pkg;

    // operating mode, one-hot
    typedef enum logic [1:0] {
        PTI_MODE_RUN = 2'b01,
        PTI_MODE_SAFE = 2'b10
    } pti_mode_e;

    // verdict of one channel for the last pulse frame
    typedef struct packed {
        logic value;
        logic cross_flt;
        logic short_flt;
    } pti_chan_s;

endpackage

// file: hdl/pti_chan_eval.sv
// per-channel pulse frame evaluation of one sensing input
`timescale 1ns/1ns
`default_nettype none
module pti_chan_eval import pti_pkg::*; #(
    parameter int N_CH = 8,
    parameter int CH = 0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // slot timing from the pulse generator
    input wire logic sample_en,
    input wire logic frame_end,
    input wire logic [N_CH-1:0] slot_sel,
    // field input of this channel
    input wire logic sense,
    // verdict
    output pti_chan_s res
);
    // the own pattern is low only in the own slot
    localparam logic [N_CH-1:0] OWN_MASK = {{(N_CH-1){1'b0}}, 1'b1} << CH;
    localparam logic [N_CH-1:0] ALL_LOW = {N_CH{1'b1}};

    logic [N_CH-1:0] low_mask_reg; // slots seen low so far
    logic [N_CH-1:0] low_full; // mask including this sample
    pti_chan_s res_reg; // last verdict
    pti_chan_s res_next;

    assign low_full = low_mask_reg | (slot_sel & {N_CH{sample_en & ~sense}});

    // classify the frame pattern
    always_comb begin
        res_next = res_reg;
        if (frame_end) begin
            res_next.value = (low_full == OWN_MASK);
            res_next.short_flt = (low_full == '0);
            // all low is an open contact, no fault
            res_next.cross_flt = (low_full != '0) && (low_full != ALL_LOW)
                && (low_full != OWN_MASK);
        end
    end

    // collect low samples over one frame
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            low_mask_reg <= '0;
            res_reg <= '0;
        end else begin
            low_mask_reg <= frame_end ? '0 : low_full;
            res_reg <= res_next;
        end
    end

    assign res = res_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    open_is_zero_a: assert property (frame_end && low_full == ALL_LOW
        |=> !res.value && !res.cross_flt && !res.short_flt)
        else $error("open or 0 V input not read as clean 0");
    stuck_high_a: assert property (frame_end && low_full == '0
        |=> res.short_flt && !res.value)
        else $error("input stuck high not flagged");
    cross_flag_a: assert property (frame_end && sample_en && !sense
        && slot_sel != OWN_MASK && low_full != ALL_LOW |=> res.cross_flt)
        else $error("foreign pulse pattern not flagged");
    own_follow_a: assert property (frame_end && low_full == OWN_MASK
        |=> res.value && !res.cross_flt)
        else $error("own pattern not read as 1");

endmodule // pti_chan_eval
`default_nettype wire

// file: hdl/pti_safe_inputs.sv
// eight-channel pulse-tested safety input front end with register port
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "pti_map.svh"
module pti_safe_inputs import pti_pkg::*; #(
    parameter int N_CH = 8,
    parameter int ADDR_W = 10,
    parameter int SLOT_CYC = `PTI_SLOT_US * `PTI_CLK_MHZ,
    parameter int BLINK_CYC = `PTI_BLINK_MS * 1000 * `PTI_CLK_MHZ
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // field side
    input wire logic [N_CH-1:0] sensing_input,
    output logic [N_CH-1:0] test_pulse_output,
    // protocol layer side
    input wire logic comm_err,
    input wire logic data_err,
    input wire logic self_check_fail,
    input wire logic [ADDR_W-1:0] addr_switch,
    output logic [N_CH-1:0] input_bits,
    output logic safe_state,
    // indicators
    output logic [N_CH-1:0] status_led,
    output logic ext_err_led,
    output logic int_err_led,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // parameter checks
    if (N_CH != 8) begin : g_chk_ch
        $error("channel count must be 8");
    end
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_aw
        $error("address width must be 1 to 16");
    end
    if (SLOT_CYC < 2 || BLINK_CYC < 1) begin : g_chk_cyc
        $error("slot and blink counts too small");
    end

    localparam int SW = `PTI_ST_W;

    // pulse slot timing
    logic [31:0] slot_cnt_reg; // cycles into the slot
    logic [2:0] slot_reg; // current slot index
    logic [N_CH-1:0] slot_sel; // one-hot of current slot
    logic sample_en; // last cycle of a slot
    logic frame_end; // last cycle of the last slot
    logic [N_CH-1:0] pulse_reg; // pulse pins

    // channel verdicts
    pti_chan_s chan_res [N_CH]; // per channel result
    logic [N_CH-1:0] val_w; // per channel value
    logic [N_CH-1:0] cross_w; // per channel cross fault
    logic [N_CH-1:0] short_w; // per channel short fault
    logic any_fault; // field fault present

    // mode and outputs
    pti_mode_e mode_reg; // run or safe
    pti_mode_e mode_next;
    logic int_fault_reg; // latched self-check fault
    logic [N_CH-1:0] in_bits_reg; // reported bits
    logic [N_CH-1:0] led_reg; // channel indicators
    logic ext_led_reg; // external error light
    logic blink_reg; // blink phase
    logic [31:0] blink_cnt_reg; // blink half period count

    // addressing
    logic addr_taken_reg; // switch captured
    logic [ADDR_W-1:0] sw_addr_reg; // captured switch address
    logic [ADDR_W-1:0] cfg_addr_reg; // configured controller address
    logic mismatch; // configured and switch differ

    // registers
    logic [SW-1:0] status_reg; // sticky events
    logic [SW-1:0] status_next;
    logic [SW-1:0] mask_reg; // interrupt mask
    logic [SW-1:0] ev_set; // events this cycle
    logic [31:0] rdata_reg; // read answer
    logic [31:0] rdata_next;
    logic irq_reg; // interrupt line

    // decode
    logic wr_ctrl, wr_mask, wr_cfg, rd_status;
    logic ack_wr; // fail-safe acknowledge

    assign wr_ctrl = reg_wr && (reg_addr == `PTI_OFS_CTRL);
    assign wr_mask = reg_wr && (reg_addr == `PTI_OFS_MASK);
    assign wr_cfg = reg_wr && (reg_addr == `PTI_OFS_CFGADDR);
    assign rd_status = reg_rd && (reg_addr == `PTI_OFS_STATUS);
    assign ack_wr = wr_ctrl && reg_wdata[`PTI_CTRL_ACK];

    // slot decode
    assign sample_en = (slot_cnt_reg == 32'(SLOT_CYC - 1));
    assign frame_end = sample_en && (slot_reg == 3'(N_CH - 1));
    assign slot_sel = {{(N_CH-1){1'b0}}, 1'b1} << slot_reg;

    // slot counter and pulse pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slot_cnt_reg <= '0;
            slot_reg <= '0;
            pulse_reg <= '1;
        end else begin
            slot_cnt_reg <= sample_en ? '0 : slot_cnt_reg + 32'h1;
            if (sample_en) begin
                slot_reg <= slot_reg + 3'h1;
            end
            pulse_reg <= ~slot_sel;
        end
    end

    // one evaluator per channel, fed by its own pulse
    for (genvar c = 0; c < N_CH; c++) begin : g_chan
        pti_chan_eval #(
            .N_CH(N_CH),
            .CH(c)
        ) u_eval (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .sample_en(sample_en),
            .frame_end(frame_end),
            .slot_sel(slot_sel),
            .sense(sensing_input[c]),
            .res(chan_res[c])
        );
        assign val_w[c] = chan_res[c].value;
        assign cross_w[c] = chan_res[c].cross_flt;
        assign short_w[c] = chan_res[c].short_flt;
    end

    assign any_fault = |cross_w || |short_w;

    // mode transitions
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            PTI_MODE_RUN: begin
                if (comm_err || int_fault_reg || self_check_fail) begin
                    mode_next = PTI_MODE_SAFE;
                end
            end
            PTI_MODE_SAFE: begin
                // leave only on acknowledge with no cause left
                if (ack_wr && !comm_err && !int_fault_reg && !self_check_fail) begin
                    mode_next = PTI_MODE_RUN;
                end
            end
            default: mode_next = PTI_MODE_SAFE;
        endcase
    end

    // mode, reported bits, channel lights
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_reg <= PTI_MODE_SAFE;
            int_fault_reg <= 1'b0;
            in_bits_reg <= '0;
            led_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            int_fault_reg <= int_fault_reg | self_check_fail;
            in_bits_reg <= (mode_reg == PTI_MODE_SAFE) ? '0 : val_w;
            led_reg <= val_w;
        end
    end

    // blink timebase for the data error
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg == 32'(BLINK_CYC - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end

    // external error light: steady wins over blink
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_led_reg <= 1'b0;
        end else begin
            ext_led_reg <= any_fault || (data_err && blink_reg);
        end
    end

    // capture the code switch once after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_taken_reg <= 1'b0;
            sw_addr_reg <= '0;
        end else if (!addr_taken_reg) begin
            addr_taken_reg <= 1'b1;
            sw_addr_reg <= addr_switch;
        end
    end

    assign mismatch = addr_taken_reg && (cfg_addr_reg != sw_addr_reg);

    // event sources for the status register
    always_comb begin
        ev_set = '0;
        ev_set[`PTI_ST_CROSS] = |cross_w;
        ev_set[`PTI_ST_SHORT] = |short_w;
        ev_set[`PTI_ST_COMM] = comm_err;
        ev_set[`PTI_ST_DATA] = data_err;
        ev_set[`PTI_ST_INT] = int_fault_reg;
        ev_set[`PTI_ST_ADDR] = mismatch;
    end

    // read clears, a new event wins over the clear
    assign status_next = (rd_status ? '0 : status_reg) | ev_set;

    // read mux
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `PTI_OFS_CTRL: rdata_next[`PTI_CTRL_ACK] = (mode_reg == PTI_MODE_SAFE);
                `PTI_OFS_STATUS: rdata_next[SW-1:0] = status_reg;
                `PTI_OFS_MASK: rdata_next[SW-1:0] = mask_reg;
                `PTI_OFS_INPUT: begin
                    rdata_next[N_CH-1:0] = in_bits_reg;
                    rdata_next[`PTI_INPUT_RAW_LSB +: N_CH] = val_w;
                end
                `PTI_OFS_FAULT: begin
                    rdata_next[N_CH-1:0] = cross_w;
                    rdata_next[`PTI_FAULT_SHORT_LSB +: N_CH] = short_w;
                end
                `PTI_OFS_ADDR: begin
                    rdata_next[ADDR_W-1:0] = sw_addr_reg;
                    rdata_next[`PTI_ADDR_MISMATCH] = mismatch;
                end
                `PTI_OFS_CFGADDR: rdata_next[ADDR_W-1:0] = cfg_addr_reg;
                default: rdata_next = '0; // unmapped reads zero
            endcase
        end
    end

    // register file and interrupt line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_reg <= '0;
            mask_reg <= SW'(`PTI_MASK_RST);
            cfg_addr_reg <= ADDR_W'(`PTI_CFGADDR_RST);
            rdata_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= reg_wdata[SW-1:0];
            end
            if (wr_cfg) begin
                cfg_addr_reg <= reg_wdata[ADDR_W-1:0];
            end
            rdata_reg <= rdata_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // outputs straight from flops
    assign test_pulse_output = pulse_reg;
    assign input_bits = in_bits_reg;
    assign safe_state = mode_reg[1]; // safe bit of the one-hot mode flop
    assign status_led = led_reg;
    assign ext_err_led = ext_led_reg;
    assign int_err_led = int_fault_reg;
    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // comm error reaches safe state and zero bits in two cycles
    sequence s_safe_reached;
        safe_state ##1 (input_bits == '0);
    endsequence

    comm_safe_a: assert property (comm_err |=> s_safe_reached)
        else $error("comm error did not force safe zero bits");
    safe_zero_a: assert property (safe_state |=> input_bits == '0)
        else $error("input bits nonzero in safe state");
    one_low_a: assert property ($countones(~test_pulse_output) <= 1)
        else $error("more than one pulse output low");
    pulse_own_slot_a: assert property (sample_en |->
        test_pulse_output == ~slot_sel)
        else $error("pulse low outside own slot");

    sequence s_internal_hold;
        int_err_led ##1 (safe_state && input_bits == '0) [*3];
    endsequence

    internal_err_a: assert property (self_check_fail |=> s_internal_hold)
        else $error("internal fault not lit or not safe");
    status_led_a: assert property ((input_bits & ~status_led) == '0)
        else $error("reported 1 with dark status light");
    ext_steady_a: assert property (any_fault [*2] |=> ext_err_led)
        else $error("field fault not shown steadily");
    ext_dark_a: assert property (!any_fault && !data_err |=> !ext_err_led)
        else $error("external light lit without error");
    addr_match_a: assert property (wr_cfg ##1 addr_taken_reg
        |-> mismatch == ($past(reg_wdata[ADDR_W-1:0]) != sw_addr_reg))
        else $error("address compare wrong");
    irq_level_a: assert property (##1 irq == |($past(status_next) & $past(mask_reg)))
        else $error("interrupt level does not follow status and mask");

    // data error alone: the light copies the blink phase
    ext_blink_a: assert property (data_err && !any_fault
        |=> ext_err_led == $past(blink_reg))
        else $error("data error light does not follow blink phase");

    // switch address stays frozen once captured
    addr_hold_a: assert property (addr_taken_reg |=> $stable(sw_addr_reg))
        else $error("captured switch address changed");

    // safe state is only left by the software acknowledge
    safe_leave_a: assert property ($fell(safe_state) |-> $past(ack_wr))
        else $error("safe state left without acknowledge");

    // a comm error is always recorded, even against a read clear
    comm_sticky_a: assert property (comm_err |=> status_reg[`PTI_ST_COMM])
        else $error("comm error not recorded in status");

    // internal fault light holds until reset
    int_latch_a: assert property (int_err_led |=> int_err_led)
        else $error("internal error light dropped before reset");

endmodule // pti_safe_inputs
`default_nettype wire

// file: verif/pti_contacts.sv
// behavioural model of the dry safety contacts wired to the pulse loops
`timescale 1ns/1ns
`default_nettype none
module pti_contacts (
    // pulse pins of the block
    input wire logic [7:0] test_pulse_output,
    // contact state per channel, two bits each
    input wire logic [15:0] mode,
    // sensing pins of the block
    output logic [7:0] sensing_input
);
    // 0 open, 1 closed on own loop, 2 shorted to supply, 3 wired to next loop
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            case (mode[2*c +: 2])
                2'h1: sensing_input[c] = test_pulse_output[c];
                2'h2: sensing_input[c] = 1'b1;
                2'h3: sensing_input[c] = test_pulse_output[(c + 1) % 8];
                default: sensing_input[c] = 1'b0; // open or shorted to 0 V
            endcase
        end
    end
endmodule // pti_contacts
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the eight-channel pulse-tested safety input block
`timescale 1ns/1ns
`default_nettype none
`include "pti_map.svh"
module testbench;
    // design signals
    logic ref_clk, rst_n, comm_err, data_err, self_check_fail, reg_wr, reg_rd;
    logic [7:0] sensing_input, test_pulse_output, input_bits, status_led, reg_addr;
    logic [9:0] addr_switch;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic safe_state, ext_err_led, int_err_led, irq;
    // contact model state and expectations
    logic [15:0] mode_bus, mode_word;
    logic [7:0] ev, cr, sh, seen_low;
    logic seen_hi, seen_lo;
    int mode [8];
    int bad_count, compares, multi, r;

    pti_safe_inputs #(.SLOT_CYC(4), .BLINK_CYC(4)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .sensing_input(sensing_input), .test_pulse_output(test_pulse_output),
        .comm_err(comm_err), .data_err(data_err), .self_check_fail(self_check_fail),
        .addr_switch(addr_switch), .input_bits(input_bits), .safe_state(safe_state),
        .status_led(status_led), .ext_err_led(ext_err_led), .int_err_led(int_err_led),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    pti_contacts i_contacts (.test_pulse_output(test_pulse_output), .mode(mode_bus),
        .sensing_input(sensing_input));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare one observed value with its expectation
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle register read, data sampled in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // wait whole cycles and settle
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // leave safe state by software acknowledge, bounded wait
    task automatic ack();
        wr(`PTI_OFS_CTRL, 32'h1);
        for (int k = 0; k < 10 && safe_state !== 1'b0; k++) cyc(1);
        if (safe_state !== 1'b0) begin
            bad_count++;
            $display("CHECK FAILED safe_state release expected 0 seen %b", safe_state);
            give_verdict();
        end
    endtask

    // apply contact states, let three frames pass, compare with the model
    task automatic round(input bit chk_bits);
        for (int c = 0; c < 8; c++) begin
            mode_word[2*c +: 2] = 2'(mode[c]);
            ev[c] = (mode[c] == 1);
            cr[c] = (mode[c] == 3);
            sh[c] = (mode[c] == 2);
        end
        @(posedge ref_clk);
        mode_bus <= mode_word;
        cyc(100);
        rd(`PTI_OFS_STATUS, d);
        chk("status_led", 32'(status_led), 32'(ev));
        rd(`PTI_OFS_INPUT, d);
        chk("evaluated", 32'(d[15:8]), 32'(ev));
        rd(`PTI_OFS_FAULT, d);
        chk("fault", d, {16'h0, sh, cr});
        chk("ext_err_led", 32'(ext_err_led), 32'(|{cr, sh}));
        rd(`PTI_OFS_STATUS, d);
        chk("status faults", d & 32'h3, {30'h0, |sh, |cr});
        if (chk_bits && !(|{cr, sh})) chk("input_bits", 32'(input_bits), 32'(ev));
    endtask

    // watchdog against hangs
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        give_verdict();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        {comm_err, data_err, self_check_fail, reg_wr, reg_rd} = 5'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        mode_bus = 16'h0;
        bad_count = 0;
        compares = 0;
        r = $urandom(61967);
        addr_switch = 10'($urandom);
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("safe_state reset", 32'(safe_state), 32'h1);
        // pulse phases over one frame: each low once, never two together
        multi = 0;
        seen_low = 8'h00;
        repeat (32) begin
            cyc(1);
            if ($countones(~test_pulse_output) > 1) multi++;
            seen_low |= ~test_pulse_output;
        end
        chk("pulse overlap", 32'(multi), 32'h0);
        chk("pulse lows", 32'(seen_low), 32'hff);
        // register reset values, unmapped and read-only places
        rd(`PTI_OFS_MASK, d);
        chk("mask reset", d, 32'h0);
        rd(`PTI_OFS_CFGADDR, d);
        chk("cfgaddr reset", d, 32'h0);
        rd(8'h1c, d);
        chk("unmapped", d, 32'h0);
        wr(`PTI_OFS_ADDR, 32'h3ff);
        wr(`PTI_OFS_CFGADDR, {22'h0, addr_switch ^ 10'h1});
        rd(`PTI_OFS_ADDR, d);
        chk("addr mismatch", d, {15'h0, 1'b1, 6'h0, addr_switch});
        cyc(1);
        chk("rdata idle", reg_rdata, 32'h0);
        rd(`PTI_OFS_STATUS, d);
        chk("status addr", d & 32'h20, 32'h20);
        wr(`PTI_OFS_CFGADDR, {22'h0, addr_switch});
        rd(`PTI_OFS_ADDR, d);
        chk("addr match", d, {22'h0, addr_switch});
        // closed contacts while still safe report zero
        for (int c = 0; c < 8; c++) mode[c] = 1;
        round(1'b0);
        chk("bits in safe", 32'(input_bits), 32'h0);
        ack();
        round(1'b1);
        // comm error with interrupt enabled
        wr(`PTI_OFS_MASK, 32'h3f);
        rd(`PTI_OFS_STATUS, d);
        cyc(2);
        chk("irq idle", 32'(irq), 32'h0);
        @(posedge ref_clk);
        comm_err <= 1'b1;
        @(posedge ref_clk);
        comm_err <= 1'b0;
        cyc(2);
        chk("safe on comm", 32'(safe_state), 32'h1);
        chk("bits on comm", 32'(input_bits), 32'h0);
        chk("irq on comm", 32'(irq), 32'h1);
        rd(`PTI_OFS_STATUS, d);
        chk("status comm", d, 32'h4);
        cyc(2);
        chk("irq cleared", 32'(irq), 32'h0);
        // masked event sets status but no interrupt
        wr(`PTI_OFS_MASK, 32'h0);
        @(posedge ref_clk);
        comm_err <= 1'b1;
        @(posedge ref_clk);
        comm_err <= 1'b0;
        cyc(3);
        chk("irq masked", 32'(irq), 32'h0);
        rd(`PTI_OFS_STATUS, d);
        chk("status masked", d, 32'h4);
        ack();
        // data error blinks the external light
        @(posedge ref_clk);
        data_err <= 1'b1;
        {seen_hi, seen_lo} = 2'b00;
        cyc(4);
        repeat (16) begin
            cyc(1);
            if (ext_err_led === 1'b1) seen_hi = 1'b1;
            if (ext_err_led === 1'b0) seen_lo = 1'b1;
        end
        chk("blink", {30'h0, seen_hi, seen_lo}, 32'h3);
        rd(`PTI_OFS_STATUS, d);
        chk("status data", d & 32'h8, 32'h8);
        @(posedge ref_clk);
        data_err <= 1'b0;
        cyc(2);
        rd(`PTI_OFS_STATUS, d);
        if (safe_state === 1'b1) ack();
        // random contact states, then all open, then all shorted
        for (int n = 0; n < 8; n++) begin
            for (int c = 0; c < 8; c++) begin
                mode[c] = (n == 6) ? 0 : (n == 7) ? 2 : int'($urandom_range(0, 3));
            end
            round(1'b1);
        end
        // internal self-check fault is latched until reset
        @(posedge ref_clk);
        self_check_fail <= 1'b1;
        @(posedge ref_clk);
        self_check_fail <= 1'b0;
        cyc(3);
        chk("int_err_led", 32'(int_err_led), 32'h1);
        chk("safe on self", 32'(safe_state), 32'h1);
        wr(`PTI_OFS_CTRL, 32'h1);
        cyc(3);
        chk("safe held", 32'(safe_state), 32'h1);
        chk("bits held", 32'(input_bits), 32'h0);
        // mid-run reset clears the latch, safe state again, then release
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("int_err_led reset", 32'(int_err_led), 32'h0);
        chk("safe after reset", 32'(safe_state), 32'h1);
        chk("bits after reset", 32'(input_bits), 32'h0);
        ack();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
